// >>> rtl/psau_addr_gen.sv
`include "psau_defines.svh"

module psau_addr_gen
  import psau_pkg::*;
(
  // page registers
  input  wire logic [7:0]  table_page_select,
  input  wire logic [7:0]  remap_page_select,
  // effective addresses
  input  wire logic [15:0] tbl_ea,
  input  wire logic [15:0] ds_ea,
  // formed program addresses
  output logic      [23:0] tbl_addr,
  output logic      [23:0] win_addr,
  // region decode
  output logic             tbl_cfg,
  output logic             tbl_ee,
  output logic             tbl_impl,
  output logic             win_ee
);

  assign tbl_addr = {table_page_select, tbl_ea};
  assign tbl_cfg  = table_page_select[`PSAU_CFG_BIT];
  assign tbl_ee   = (table_page_select == `PSAU_EE_TBL_PAGE);
  // in config space only the id page is implemented
  assign tbl_impl = !tbl_cfg || (table_page_select == `PSAU_ID_PAGE);
  // page then low 15 bits; top bit zero; bit 15 from page bit 0
  // each page value picks a 16K-word page
  assign win_addr = {1'b0, remap_page_select, ds_ea[14:0]};
  assign win_ee   = (remap_page_select == `PSAU_REMAP_EE_PAGE);

endmodule

// >>> rtl/psau_defines.svh
`ifndef PSAU_DEFINES_SVH
`define PSAU_DEFINES_SVH

// register offsets on the plain register port
`define PSAU_REG_TABLE_PAGE  4'h0
`define PSAU_REG_REMAP_PAGE  4'h1
`define PSAU_REG_WIN_CTRL    4'h2
`define PSAU_REG_STATUS      4'h3

// reset values
`define PSAU_TABLE_PAGE_RST  8'h00
`define PSAU_REMAP_PAGE_RST  8'h00
`define PSAU_WIN_EN_RST      1'b0

// field positions
`define PSAU_WIN_EN_BIT      0
`define PSAU_STAT_TBL_BUSY   0
`define PSAU_STAT_WIN_BUSY   1
`define PSAU_STAT_REJ_LSB    8
`define PSAU_CFG_BIT         7

// page codes
`define PSAU_EE_TBL_PAGE     8'h7F
`define PSAU_REMAP_PROG_PAGE 8'h00
`define PSAU_REMAP_EE_PAGE   8'hFF
`define PSAU_ID_PAGE         8'hFF

// program counter step per program word
`define PSAU_PC_STEP         23'h000002

`endif

// >>> rtl/psau_lane_mux.sv
module psau_lane_mux (
  // operation shape
  input  wire logic        hi_op,
  input  wire logic        byte_mode,
  input  wire logic        bsel,
  input  wire logic        zero,
  // program word in, data word out
  input  wire logic [23:0] word,
  output logic      [15:0] data
);

  // lane selection for table reads
  always_comb begin
    data = 16'h0000;
    if (zero) begin
      data = 16'h0000;
    end else if (!hi_op && !byte_mode) begin
      data = word[15:0];
    end else if (!hi_op) begin
      // byte of low word to low lane
      data = {8'h00, (bsel ? word[15:8] : word[7:0])};
    end else if (!byte_mode) begin
      data = {8'h00, word[23:16]};
    end else begin
      data = {8'h00, (bsel ? 8'h00 : word[23:16])};
    end
  end

endmodule

// >>> rtl/psau_pkg.sv
package psau_pkg;

  // table operation codes from the core
  typedef enum logic [1:0] {
    PSAU_OP_RD_LOW,
    PSAU_OP_RD_HIGH,
    PSAU_OP_WR_LOW,
    PSAU_OP_WR_HIGH
  } psau_op_e;

  // sequencer states
  typedef enum logic [2:0] {
    PSAU_ST_IDLE,
    PSAU_ST_T_ISSUE,
    PSAU_ST_T_DATA,
    PSAU_ST_T_WRITE,
    PSAU_ST_W_F1,
    PSAU_ST_W_F2,
    PSAU_ST_W_DATA
  } psau_state_e;

endpackage

// >>> rtl/psau_top.sv
// Behaviour
// - table address is page over effective address
// - page bit 7 picks config space
// - window address is page plus 15 bits
// - each window page is 16K words
// - window address bit 23 always zero
// - window bit 15 comes from page bit 0
// - window path is read-only, low word only
// - program counter steps by two per word
// - table ops need no alignment, config reads allowed
// - low word read returns bits 15:0
// - low byte read picks byte by select
// - high word read returns upper byte, zero-extended
// - high byte read with select one is zero
// - only high table ops touch upper byte
// - low table ops reach eeprom, high ops not
// - config writes dropped, reads only implemented areas
// - window read costs one extra cycle
// - window waits while table op runs
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "psau_defines.svh"

module psau_top
  import psau_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // table operation request
  input  wire logic        tbl_req,
  input  wire logic [1:0]  tbl_op,
  input  wire logic        tbl_byte,
  input  wire logic [15:0] tbl_ea,
  input  wire logic [15:0] tbl_wdata,
  output logic             tbl_ready,
  output logic             tbl_done,
  output logic      [15:0] tbl_rdata,
  // data-space access
  input  wire logic        ds_req,
  input  wire logic        ds_we,
  input  wire logic [15:0] ds_ea,
  output logic             ds_hit,
  output logic             ds_wait,
  output logic             ds_done,
  output logic      [15:0] ds_rdata,
  // instruction fetch counter
  input  wire logic        pc_load,
  input  wire logic [22:0] pc_load_val,
  input  wire logic        fetch_adv,
  output logic      [23:0] fetch_addr,
  // program memory read port, data one cycle after strobe
  output logic             mem_rd,
  output logic      [23:0] mem_addr,
  output logic             mem_ee,
  input  wire logic [23:0] mem_rdata,
  // write holding latches
  output logic             latch_wr,
  output logic      [23:0] latch_addr,
  output logic      [23:0] latch_wdata,
  output logic      [2:0]  latch_be,
  output logic             latch_ee
);

  // software-visible registers
  logic [7:0]  table_page_select;   // table page
  logic [7:0]  remap_page_select;   // window page
  logic        win_en;              // window enable
  logic [7:0]  reject_cnt;          // rejected config writes

  // sequencer
  psau_state_e state;               // current state
  psau_state_e next_state;          // next state

  // request captured at take
  logic        op_high;             // high-byte operation
  logic        op_byte;             // byte mode
  logic        op_bsel;             // byte select
  logic        op_zero;             // read returns zero
  logic        next_op_zero;        // zero decision at take

  // decoded addresses
  logic [23:0] tbl_addr;            // table program address
  logic [23:0] win_addr;            // window program address
  logic        tbl_cfg;             // config space
  logic        tbl_ee;              // eeprom page
  logic        tbl_impl;            // implemented area
  logic        win_ee;              // window on eeprom
  logic [15:0] lane_data;           // mapped read data
  logic [22:0] pc_q;                // program counter

  // takes in the idle state
  logic        take_tbl;            // table op accepted
  logic        take_win;            // window read accepted
  logic        take_win_wr;         // window write dropped
  logic        wr_allowed;          // table write may proceed
  logic [2:0]  wr_be;               // lanes of a table write
  logic [23:0] wr_word;             // placed table write data

  // lanes of a write into the 24-bit word
  function automatic logic [2:0] psau_wr_lanes(input logic hi, input logic by,
                                               input logic bs);
    logic [2:0] be;
    be = 3'b000;
    // upper lane only from high ops
    if (hi) begin
      be = (by && bs) ? 3'b000 : 3'b100;
    end else if (by) begin
      be = bs ? 3'b010 : 3'b001;
    end else begin
      be = 3'b011;
    end
    return be;
  endfunction

  // data placed onto the write lanes
  function automatic logic [23:0] psau_wr_data(input logic hi, input logic by,
                                               input logic [15:0] d);
    logic [23:0] w;
    w = 24'h000000;
    if (hi) begin
      w = {d[7:0], 16'h0000};
    end else if (by) begin
      w = {8'h00, d[7:0], d[7:0]};
    end else begin
      w = {8'h00, d};
    end
    return w;
  endfunction

  // address formation
  psau_addr_gen u_addr (
    .table_page_select (table_page_select),
    .remap_page_select (remap_page_select),
    .tbl_ea            (tbl_ea),
    .ds_ea             (ds_ea),
    .tbl_addr          (tbl_addr),
    .win_addr          (win_addr),
    .tbl_cfg           (tbl_cfg),
    .tbl_ee            (tbl_ee),
    .tbl_impl          (tbl_impl),
    .win_ee            (win_ee)
  );

  // read lane mapping, fed straight from memory
  psau_lane_mux u_lane (
    .hi_op     (op_high),
    .byte_mode (op_byte),
    .bsel      (op_bsel),
    .zero      (op_zero),
    .word      (mem_rdata),
    .data      (lane_data)
  );

  // window hit on upper half of data space
  assign ds_hit = ds_req && ds_ea[15] && win_en;

  // table ops are accepted only when idle
  assign tbl_ready = (state == PSAU_ST_IDLE);
  assign take_tbl  = tbl_ready && tbl_req;

  // table requests win over the window
  assign take_win    = tbl_ready && !tbl_req && ds_hit && !ds_we && !ds_done;
  assign take_win_wr = tbl_ready && !tbl_req && ds_hit && ds_we && !ds_done;

  // hold the core while the window is blocked or busy
  assign ds_wait = ds_hit && !ds_done;

  // no table writes in config space
  assign wr_allowed = !tbl_cfg;
  assign wr_be      = psau_wr_lanes(tbl_op == PSAU_OP_WR_HIGH, tbl_byte,
                                    tbl_ea[0]);
  assign wr_word    = psau_wr_data(tbl_op == PSAU_OP_WR_HIGH, tbl_byte,
                                   tbl_wdata);

  // reads that never go to memory return zero
  always_comb begin
    next_op_zero = 1'b0;
    if (!tbl_impl) begin
      next_op_zero = 1'b1;
    end
    // high ops are not used on the eeprom
    if (tbl_ee && tbl_op == PSAU_OP_RD_HIGH) begin
      next_op_zero = 1'b1;
    end
  end

  // state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      PSAU_ST_IDLE: begin
        if (take_tbl && (tbl_op == PSAU_OP_RD_LOW || tbl_op == PSAU_OP_RD_HIGH)) begin
          next_state = PSAU_ST_T_ISSUE;
        end else if (take_tbl) begin
          next_state = PSAU_ST_T_WRITE;
        end else if (take_win) begin
          next_state = PSAU_ST_W_F1;
        end
      end
      PSAU_ST_T_ISSUE: next_state = PSAU_ST_T_DATA;
      PSAU_ST_T_DATA:  next_state = PSAU_ST_IDLE;
      PSAU_ST_T_WRITE: next_state = PSAU_ST_IDLE;
      PSAU_ST_W_F1:    next_state = PSAU_ST_W_F2;
      PSAU_ST_W_F2:    next_state = PSAU_ST_W_DATA;
      PSAU_ST_W_DATA:  next_state = PSAU_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= PSAU_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // register writes from software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      table_page_select <= `PSAU_TABLE_PAGE_RST;
      remap_page_select <= `PSAU_REMAP_PAGE_RST;
      win_en            <= `PSAU_WIN_EN_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `PSAU_REG_TABLE_PAGE: table_page_select <= reg_wdata[7:0];
        // any value stored, only 00 and FF meaningful
        `PSAU_REG_REMAP_PAGE: remap_page_select <= reg_wdata[7:0];
        `PSAU_REG_WIN_CTRL:   win_en <= reg_wdata[`PSAU_WIN_EN_BIT];
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PSAU_REG_TABLE_PAGE: reg_rdata <= {8'h00, table_page_select};
        `PSAU_REG_REMAP_PAGE: reg_rdata <= {8'h00, remap_page_select};
        `PSAU_REG_WIN_CTRL:   reg_rdata <= {15'h0000, win_en};
        `PSAU_REG_STATUS: begin
          reg_rdata <= 16'h0000;
          reg_rdata[`PSAU_STAT_REJ_LSB +: 8] <= reject_cnt;
          reg_rdata[`PSAU_STAT_TBL_BUSY] <= (state == PSAU_ST_T_ISSUE) ||
                                            (state == PSAU_ST_T_DATA) ||
                                            (state == PSAU_ST_T_WRITE);
          reg_rdata[`PSAU_STAT_WIN_BUSY] <= (state == PSAU_ST_W_F1) ||
                                            (state == PSAU_ST_W_F2) ||
                                            (state == PSAU_ST_W_DATA);
        end
        // unmapped offsets read zero
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      // data stands for one cycle only
      reg_rdata <= 16'h0000;
    end
  end

  // operation shape held for the lane mux
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      op_high <= 1'b0;
      op_byte <= 1'b0;
      op_bsel <= 1'b0;
      op_zero <= 1'b0;
    end else if (take_tbl) begin
      op_high <= (tbl_op == PSAU_OP_RD_HIGH) || (tbl_op == PSAU_OP_WR_HIGH);
      op_byte <= tbl_byte;
      // byte select from address bit 0, no alignment trap
      op_bsel <= tbl_ea[0];
      op_zero <= next_op_zero;
    end else if (take_win) begin
      // window reads take the low word only
      op_high <= 1'b0;
      op_byte <= 1'b0;
      op_bsel <= 1'b0;
      op_zero <= 1'b0;
    end
  end

  // program memory read strobe and address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_rd   <= 1'b0;
      mem_addr <= 24'h000000;
      mem_ee   <= 1'b0;
    end else if (take_tbl && (tbl_op == PSAU_OP_RD_LOW || tbl_op == PSAU_OP_RD_HIGH)) begin
      // config reads allowed; skip unimplemented areas
      mem_rd   <= !next_op_zero;
      mem_addr <= {tbl_addr[23:1], 1'b0};
      mem_ee   <= tbl_ee;
    end else if (take_win) begin
      mem_rd   <= 1'b1;
      mem_addr <= {win_addr[23:1], 1'b0};
      mem_ee   <= win_ee;
    end else if (state == PSAU_ST_W_F1) begin
      // second fetch of the same word
      mem_rd <= 1'b1;
    end else begin
      mem_rd <= 1'b0;
    end
  end

  // write holding latches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_wr    <= 1'b0;
      latch_addr  <= 24'h000000;
      latch_wdata <= 24'h000000;
      latch_be    <= 3'b000;
      latch_ee    <= 1'b0;
    end else if (take_tbl && (tbl_op == PSAU_OP_WR_LOW || tbl_op == PSAU_OP_WR_HIGH)) begin
      // rejected writes leave the latch port idle
      latch_wr    <= wr_allowed && (wr_be != 3'b000) &&
                     !(tbl_ee && tbl_op == PSAU_OP_WR_HIGH);
      latch_addr  <= {tbl_addr[23:1], 1'b0};
      latch_wdata <= wr_word;
      latch_be    <= wr_be;
      latch_ee    <= tbl_ee;
    end else begin
      latch_wr <= 1'b0;
    end
  end

  // count rejected config writes, wraps
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reject_cnt <= 8'h00;
    end else if (take_tbl && !wr_allowed &&
                 (tbl_op == PSAU_OP_WR_LOW || tbl_op == PSAU_OP_WR_HIGH)) begin
      reject_cnt <= reject_cnt + 8'h01;
    end
  end

  // table completion and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tbl_done  <= 1'b0;
      tbl_rdata <= 16'h0000;
    end else begin
      // write completes in fixed time, accepted or not
      tbl_done <= (state == PSAU_ST_T_DATA) || (state == PSAU_ST_T_WRITE);
      if (state == PSAU_ST_T_DATA) begin
        tbl_rdata <= lane_data;
      end
    end
  end

  // window completion and read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ds_done  <= 1'b0;
      ds_rdata <= 16'h0000;
    end else begin
      ds_done <= (state == PSAU_ST_W_DATA) || take_win_wr;
      if (state == PSAU_ST_W_DATA) begin
        ds_rdata <= mem_rdata[15:0];
      end
    end
  end

  // instruction fetch counter, bit 0 always clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_q <= 23'h000000;
    end else if (pc_load) begin
      pc_q <= {pc_load_val[22:1], 1'b0};
    end else if (fetch_adv) begin
      // two address units per program word
      pc_q <= pc_q + `PSAU_PC_STEP;
    end
  end

  // instruction space sits in user memory
  assign fetch_addr = {1'b0, pc_q};

endmodule

// >>> sim/program_space_access_unit_tb.sv
`include "psau_defines.svh"

module program_space_access_unit_tb
  import psau_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0]  pg;
    psau_op_e    op;
    logic        by;
    logic [15:0] ea;
    logic [15:0] res;
  } psau_row_s;

  // core-side drives
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, tbl_req = 1'b0, tbl_byte = 1'b0;
  logic        ds_req = 1'b0, ds_we = 1'b0, pc_load = 1'b0, fetch_adv = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [1:0]  tbl_op = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, tbl_ea = 16'h0000, tbl_wdata = 16'h0000;
  logic [15:0] ds_ea = 16'h0000;
  logic [22:0] pc_load_val = 23'h000000;
  // block outputs
  logic [15:0] reg_rdata, tbl_rdata, ds_rdata, rd;
  logic        tbl_ready, tbl_done, ds_hit, ds_wait, ds_done, mem_rd, mem_ee;
  logic        latch_wr, latch_ee, seen_lw, seen_mr;
  logic [23:0] fetch_addr, mem_addr, mem_rdata, latch_addr, latch_wdata;
  logic [2:0]  latch_be;
  int          n_errors = 0, total_checks = 0, n;
  // table reads: page, op, byte mode, address, result
  psau_row_s   rows [10] = '{
    '{8'h00, PSAU_OP_RD_LOW, 1'b0, 16'h1234, 16'h1234},
    '{8'h12, PSAU_OP_RD_LOW, 1'b1, 16'h5679, 16'h0044},
    '{8'h12, PSAU_OP_RD_LOW, 1'b1, 16'h5678, 16'h0078},
    '{8'h12, PSAU_OP_RD_HIGH, 1'b0, 16'h5678, 16'h00F3},
    '{8'h12, PSAU_OP_RD_HIGH, 1'b1, 16'h5678, 16'h00F3},
    '{8'h12, PSAU_OP_RD_HIGH, 1'b1, 16'h5679, 16'h0000},
    '{8'hFF, PSAU_OP_RD_LOW, 1'b0, 16'h0006, 16'hFF06},
    '{8'h80, PSAU_OP_RD_LOW, 1'b0, 16'h0006, 16'h0000},
    '{8'h7F, PSAU_OP_RD_LOW, 1'b0, 16'h0010, 16'h7F11},
    '{8'h7F, PSAU_OP_RD_HIGH, 1'b0, 16'h0010, 16'h0000}};

  always #10 ref_clk = ~ref_clk;

  psau_top i_dut (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tbl_req, .tbl_op,
    .tbl_byte, .tbl_ea, .tbl_wdata, .tbl_ready, .tbl_done, .tbl_rdata, .ds_req, .ds_we,
    .ds_ea, .ds_hit, .ds_wait, .ds_done, .ds_rdata, .pc_load, .pc_load_val, .fetch_adv,
    .fetch_addr, .mem_rd, .mem_addr, .mem_ee, .mem_rdata, .latch_wr, .latch_addr,
    .latch_wdata, .latch_be, .latch_ee);

  psau_mem_model i_mem (.ref_clk, .mem_rd, .mem_addr, .mem_ee, .mem_rdata);

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // four-state compare, widened to the widest value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_r(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // bounded wait for completion, counting cycles from the request cycle
  task automatic run(input bit win);
    n = 0;
    seen_lw = 1'b0;
    seen_mr = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      n++;
      seen_lw = seen_lw | (latch_wr === 1'b1);
      seen_mr = seen_mr | (mem_rd === 1'b1);
      if ((win ? ds_done : tbl_done) === 1'b1)
        return;
      @(posedge ref_clk);
      tbl_req <= 1'b0;
    end
    n_errors++;
    $display("Error at %0t: no completion", $time);
    close_out();
  endtask

  task automatic tbl(input psau_op_e op, input logic by, input logic [15:0] ea, d);
    @(posedge ref_clk);
    tbl_req <= 1'b1;
    tbl_op <= op;
    tbl_byte <= by;
    tbl_ea <= ea;
    tbl_wdata <= d;
    run(1'b0);
  endtask

  // ds_req is held until done, dropped at the edge ending the done cycle
  task automatic win(input logic we, input logic [15:0] ea);
    @(posedge ref_clk);
    ds_req <= 1'b1;
    ds_we <= we;
    ds_ea <= ea;
    run(1'b1);
    @(posedge ref_clk);
    ds_req <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, unmapped offsets 4 to 9 included
    foreach (rows[i]) begin
      reg_r(4'(i), rd);
      chk(rd, 16'h0000);
    end
    foreach (rows[i]) begin
      reg_w(`PSAU_REG_TABLE_PAGE, {8'h00, rows[i].pg});
      tbl(rows[i].op, rows[i].by, rows[i].ea, 16'h0000);
      chk(tbl_rdata, rows[i].res);
      chk(n, 4);
    end
    reg_r(`PSAU_REG_TABLE_PAGE, rd);
    chk(rd, 16'h007F);
    // write lanes and the writes that must not reach the latches
    reg_w(`PSAU_REG_TABLE_PAGE, 16'h0012);
    tbl(PSAU_OP_WR_LOW, 1'b0, 16'h4000, 16'hBEEF);
    chk({latch_addr, latch_wdata, latch_be, seen_lw, latch_ee}, {48'h1240_0000_BEEF, 5'hE});
    tbl(PSAU_OP_WR_LOW, 1'b1, 16'h4001, 16'h00C7);
    chk({latch_wdata, latch_be}, {24'h00C7C7, 3'h2});
    tbl(PSAU_OP_WR_HIGH, 1'b0, 16'h4002, 16'h005A);
    chk({latch_wdata, latch_be}, {24'h5A0000, 3'h4});
    tbl(PSAU_OP_WR_HIGH, 1'b1, 16'h4003, 16'h0011);
    chk(seen_lw, 1'b0);
    reg_w(`PSAU_REG_TABLE_PAGE, {8'h00, `PSAU_EE_TBL_PAGE});
    tbl(PSAU_OP_WR_HIGH, 1'b0, 16'h0000, 16'h0022);
    chk(seen_lw, 1'b0);
    reg_w(`PSAU_REG_TABLE_PAGE, 16'h0080);
    tbl(PSAU_OP_WR_LOW, 1'b0, 16'h0000, 16'h1111);
    chk({n, seen_lw}, {23'h000003, 1'b0});
    reg_w(`PSAU_REG_TABLE_PAGE, 16'h00FF);
    tbl(PSAU_OP_WR_HIGH, 1'b0, 16'h0000, 16'h2222);
    chk(seen_lw, 1'b0);
    // status is read-only, unmapped writes are ignored
    reg_w(`PSAU_REG_STATUS, 16'hFFFF);
    reg_w(4'hA, 16'hFFFF);
    reg_r(`PSAU_REG_STATUS, rd);
    chk(rd, 16'h0200);
    reg_r(4'hA, rd);
    chk(rd, 16'h0000);
    // window reads on both pages, then a write that must do nothing
    reg_w(`PSAU_REG_WIN_CTRL, 16'h0001);
    win(1'b0, 16'h8024);
    chk({ds_rdata, 8'(n)}, {16'h0024, 8'h05});
    reg_w(`PSAU_REG_REMAP_PAGE, {8'h00, `PSAU_REMAP_EE_PAGE});
    win(1'b0, 16'h8024);
    chk(ds_rdata, 16'hFF25);
    win(1'b1, 16'h8030);
    chk({n, seen_mr, seen_lw}, {22'h000002, 2'h0});
    // window request beside a table read waits for it
    reg_w(`PSAU_REG_REMAP_PAGE, {8'h00, `PSAU_REMAP_PROG_PAGE});
    reg_w(`PSAU_REG_TABLE_PAGE, 16'h0000);
    @(posedge ref_clk);
    ds_req <= 1'b1;
    ds_we <= 1'b0;
    ds_ea <= 16'h8024;
    tbl_req <= 1'b1;
    tbl_op <= PSAU_OP_RD_LOW;
    tbl_byte <= 1'b0;
    tbl_ea <= 16'h1234;
    run(1'b0);
    chk({tbl_rdata, 8'(n), ds_wait}, {16'h1234, 8'h04, 1'b1});
    run(1'b1);
    chk({ds_rdata, n > 1}, {16'h0024, 1'b1});
    @(posedge ref_clk);
    ds_req <= 1'b0;
    // counter load then three advances
    pc_load <= 1'b1;
    pc_load_val <= 23'h000101;
    @(posedge ref_clk);
    pc_load <= 1'b0;
    fetch_adv <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fetch_adv <= 1'b0;
    @(negedge ref_clk);
    chk(fetch_addr, 24'h000106);
    close_out();
  end
endmodule

// >>> sim/psau_mem_model.sv
module psau_mem_model (
  // clock
  input  wire logic        ref_clk,
  // read port
  input  wire logic        mem_rd,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_ee,
  output logic      [23:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial mem_rdata = 24'h000000;

  // word pattern from address and region, so a wrong lane or page shows;
  // outside the answer cycle the bus flips so stale data never passes
  always @(posedge ref_clk) begin
    if (mem_rd)
      mem_rdata <= {mem_addr[15:8] ^ 8'hA5, mem_addr[23:16] ^ mem_addr[15:8],
                    mem_addr[7:1], mem_ee};
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

// >>> sim/psau_props.sv
`include "psau_defines.svh"

module psau_props
  import psau_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  // table side
  input wire logic        tbl_req,
  input wire logic [1:0]  tbl_op,
  input wire logic        tbl_byte,
  input wire logic [15:0] tbl_ea,
  input wire logic [15:0] tbl_wdata,
  input wire logic        tbl_ready,
  input wire logic        tbl_done,
  input wire logic [15:0] tbl_rdata,
  // window side
  input wire logic        ds_we,
  input wire logic [15:0] ds_ea,
  input wire logic        ds_hit,
  input wire logic        ds_done,
  input wire logic [15:0] ds_rdata,
  // fetch counter
  input wire logic        pc_load,
  input wire logic        fetch_adv,
  input wire logic [23:0] fetch_addr,
  // memory and latches
  input wire logic        mem_rd,
  input wire logic [23:0] mem_addr,
  input wire logic [23:0] mem_rdata,
  input wire logic        latch_wr,
  input wire logic [23:0] latch_wdata,
  input wire logic [2:0]  latch_be
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tpg;  // shadow of table page
  logic [7:0] rpg;  // shadow of remap page
  logic       t_rd; // table read taken
  logic       t_wr; // table write taken
  logic       t_ok; // table read that reaches memory
  logic       w_rd; // window read taken

  // shadow pages, same one-cycle write latency as the block
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tpg <= 8'h00;
      rpg <= 8'h00;
    end else if (reg_wr && reg_addr == `PSAU_REG_TABLE_PAGE) begin
      tpg <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == `PSAU_REG_REMAP_PAGE) begin
      rpg <= reg_wdata[7:0];
    end
  end

  // take conditions as the handshake defines them
  assign t_rd = tbl_req && tbl_ready && !tbl_op[1];
  assign t_wr = tbl_req && tbl_ready && tbl_op[1];
  assign t_ok = t_rd && !(tpg[7] && tpg != `PSAU_ID_PAGE)
                && !(tbl_op == PSAU_OP_RD_HIGH && tpg == `PSAU_EE_TBL_PAGE);
  assign w_rd = tbl_ready && !tbl_req && ds_hit && !ds_we && !ds_done;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_tbl_addr;
    t_ok |=> mem_rd && mem_addr == {tpg, $past(tbl_ea) & 16'hFFFE};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
  property p_cfg_wr;
    t_wr && tpg[7] |=> !latch_wr ##1 tbl_done;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write not dropped");
  property p_rd_low;
    t_ok && tbl_op == PSAU_OP_RD_LOW && !tbl_byte
      |-> ##3 tbl_done && tbl_rdata == $past(mem_rdata[15:0]);
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("low word read wrong");
  property p_phantom;
    t_rd && tbl_op == PSAU_OP_RD_HIGH && tbl_byte && tbl_ea[0] |-> ##3 tbl_rdata == 16'h0000;
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom byte not zero");
  property p_wr_low;
    t_wr && tbl_op == PSAU_OP_WR_LOW && !tbl_byte && !tpg[7]
      |=> latch_wr && latch_be == 3'h3 && latch_wdata == {8'h00, $past(tbl_wdata)};
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low write lanes wrong");
  property p_win_addr;
    w_rd |=> mem_rd && mem_addr[23:1] == {1'b0, rpg, ds_ea[14:1]};
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong");
  property p_win_fetch;
    w_rd |=> mem_rd [*2] ##1 !mem_rd ##1 ds_done;
  endproperty
  a_win_fetch: assert property (p_win_fetch) else $error("window fetch count wrong");
  property p_win_data;
    w_rd |-> ##4 ds_rdata == $past(mem_rdata[15:0]) && !latch_wr;
  endproperty
  a_win_data: assert property (p_win_data) else $error("window data wrong");
  property p_tbl_first;
    t_rd |=> !ds_done [*3];
  endproperty
  a_tbl_first: assert property (p_tbl_first) else $error("window ran during table op");
  property p_pc;
    fetch_adv && !pc_load |=> fetch_addr == $past(fetch_addr) + 24'h000002;
  endproperty
  a_pc: assert property (p_pc) else $error("fetch step not two");

  // main scenarios reached
  c_tbl: cover property (t_ok ##3 tbl_done);
  c_win: cover property (w_rd ##4 ds_done);
  c_rej: cover property (t_wr && tpg[7]);
endmodule

bind psau_top psau_props i_props (
  .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .tbl_req, .tbl_op, .tbl_byte, .tbl_ea,
  .tbl_wdata, .tbl_ready, .tbl_done, .tbl_rdata, .ds_we, .ds_ea, .ds_hit, .ds_done,
  .ds_rdata, .pc_load, .fetch_adv, .fetch_addr, .mem_rd, .mem_addr, .mem_rdata, .latch_wr,
  .latch_wdata, .latch_be
);
